// >>> verilog/sps_pkg.sv
`default_nettype none
package sps_pkg;
   // ==========================================
   // register map (byte addresses)
   localparam logic [7:0] SPS_OFS_SERIAL_CONTROL_STATUS = 8'h98;
   localparam logic [7:0] SPS_OFS_AUX_CTRL   = 8'hA0;
   localparam logic [7:0] SPS_OFS_RATE_DIV   = 8'hA4;
   localparam logic [7:0] SPS_OFS_TX_DATA    = 8'hA8;
   localparam logic [7:0] SPS_OFS_RX_DATA    = 8'hAC;
   localparam logic [7:0] SPS_OFS_IRQ_STATUS = 8'hB0;
   localparam logic [7:0] SPS_OFS_IRQ_CLEAR  = 8'hB4;
   localparam logic [7:0] SPS_OFS_IRQ_ENABLE = 8'hB8;

   // ==========================================
   // field positions
   localparam int SPS_SCS_ERR_MODE_HI = 7;
   localparam int SPS_SCS_MODE_LO     = 6;
   localparam int SPS_SCS_MULTIPROC   = 5;
   localparam int SPS_SCS_RX_ENABLE   = 4;
   localparam int SPS_SCS_TX_NINTH    = 3;
   localparam int SPS_SCS_RX_NINTH    = 2;
   localparam int SPS_SCS_TX_DONE     = 1;
   localparam int SPS_SCS_RX_DONE     = 0;
   localparam int SPS_AUX_ERR_VIEW    = 0;
   localparam int SPS_AUX_DOUBLE      = 1;
   localparam int SPS_AUX_RATE_FAST   = 2;
   localparam int SPS_IRQ_TX          = 0;
   localparam int SPS_IRQ_RX          = 1;
   localparam int SPS_IRQ_FE          = 2;

   // ==========================================
   // rate divisors and bit timing
   localparam int SPS_XTAL_DIV_SHIFT    = 12;
   localparam int SPS_XTAL_DIV_SHIFT_X2 = 6;
   localparam int SPS_XTAL_DIV_SLOW     = 64;
   localparam int SPS_XTAL_DIV_FAST     = 32;
   localparam int SPS_X2_FACTOR         = 2;
   localparam int SPS_SHIFT_TICKS       = 2;
   localparam int SPS_UART_TICKS        = 16;
   localparam logic [15:0] SPS_TDIV_SHIFT =
      16'(SPS_XTAL_DIV_SHIFT / SPS_SHIFT_TICKS);
   localparam logic [15:0] SPS_TDIV_SHIFT_X2 =
      16'(SPS_XTAL_DIV_SHIFT_X2 / SPS_SHIFT_TICKS);
   localparam logic [15:0] SPS_TDIV_SLOW =
      16'(SPS_XTAL_DIV_SLOW / SPS_UART_TICKS);
   localparam logic [15:0] SPS_TDIV_FAST =
      16'(SPS_XTAL_DIV_FAST / SPS_UART_TICKS);
   localparam logic [15:0] SPS_TDIV_SLOW_X2 =
      16'(SPS_XTAL_DIV_SLOW / SPS_X2_FACTOR / SPS_UART_TICKS);
   localparam logic [15:0] SPS_TDIV_FAST_X2 =
      16'(SPS_XTAL_DIV_FAST / SPS_X2_FACTOR / SPS_UART_TICKS);
   localparam logic [3:0] SPS_SHIFT_LAST_TICK = 4'(SPS_SHIFT_TICKS - 1);
   localparam logic [3:0] SPS_UART_LAST_TICK  = 4'(SPS_UART_TICKS - 1);
   localparam logic [3:0] SPS_UART_MID_TICK   = 4'h7;
   localparam logic [3:0] SPS_LAST_BIT_EIGHT  = 4'h7;
   localparam logic [3:0] SPS_LAST_BIT_NINE   = 4'h8;

   // ==========================================
   // types
   typedef enum logic [1:0]
   {
      SPS_MODE_SHIFT = 2'h0,
      SPS_MODE_UART8 = 2'h1,
      SPS_MODE_FIXED = 2'h2,
      SPS_MODE_UART9 = 2'h3
   } sps_mode_type;

   typedef enum logic [1:0]
   {
      SPS_IDLE  = 2'h0,
      SPS_START = 2'h1,
      SPS_DATA  = 2'h3,
      SPS_STOP  = 2'h2
   } sps_fsm_type;

   typedef struct packed {
      logic        mode_select_hi;
      logic        mode_select_lo;
      logic        multiproc_enable;
      logic        rx_enable;
      logic        tx_ninth_bit;
      logic        rx_ninth_bit;
      logic        tx_done_flag;
      logic        rx_done_flag;
      logic        frame_error_flag;
      logic        error_view_select;
      logic        double_speed_clocking;
      logic        rate_fast;
      logic [15:0] var_div;
      sps_fsm_type tx_st;
      logic [8:0]  tx_sh;
      logic [3:0]  tx_bit;
      logic [3:0]  tx_tk;
      sps_fsm_type rx_st;
      logic [8:0]  rx_sh;
      logic [3:0]  rx_bit;
      logic [3:0]  rx_tk;
      logic [7:0]  rx_buf;
      logic        rxd_was_low;
      logic        txd_low;
      logic        rxd_drive;
      logic        rxd_out;
      logic [2:0]  irq_st;
      logic [2:0]  irq_en;
      logic        ack;
      logic [31:0] dat;
   } sps_state_type;

   typedef struct packed {
      logic [15:0] cnt;
      logic        tick;
   } sps_rate_state_type;

   localparam sps_state_type      SPS_STATE_RESET = '0;
   localparam sps_rate_state_type SPS_RATE_RESET  = '0;
endpackage
`default_nettype wire

// >>> verilog/sps_sync2.sv
`default_nettype none
module sps_sync2
   import sps_pkg::*;
#(
   parameter logic RESET_VAL = 1'b1
)
(
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // asynchronous level in, synchronous level out
   input  wire logic d_i,
   output logic      q_o
);
   // ==========================================
   // two-stage synchroniser
   logic [1:0] stage_r;

   // first stage feeds only the second
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         stage_r <= {2{RESET_VAL}};
      else
         stage_r <= {stage_r[0], d_i};
   end

   assign q_o = stage_r[1];
endmodule
`default_nettype wire

// >>> verilog/sps_rate_gen.sv
`default_nettype none
module sps_rate_gen
   import sps_pkg::*;
(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // divisor in system clocks, tick out
   input  wire logic [15:0] div_i,
   output logic             tick_o
);
   // ==========================================
   // free-running divider
   sps_rate_state_type r_r;
   sps_rate_state_type r_nxt;

   // one tick every div_i clocks, every clock when div_i is zero
   always_comb
   begin
      r_nxt      = r_r;
      r_nxt.tick = ({1'b0, r_r.cnt} + 17'h00001) >= {1'b0, div_i};
      r_nxt.cnt  = r_nxt.tick ? 16'h0000 : r_r.cnt + 16'h0001;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         r_r <= SPS_RATE_RESET;
      else
         r_r <= r_nxt;
   end

   assign tick_o = r_r.tick;
endmodule
`default_nettype wire

// >>> verilog/sps_serial_port.sv
// Functional notes
// [R1] A received frame whose stop bit is low sets the framing-error flag.
// [R2] The framing-error flag stays set until software writes it to zero.
// [R3] Bit 7 shows the framing-error flag when error view is on, else the high mode bit.
// [R4] The two mode bits pick shift register, 8-bit UART, fixed 9-bit or variable 9-bit.
// [R5] Shift mode runs at the crystal rate over 12, or over 6 at double speed.
// [R6] Fixed 9-bit mode runs at crystal over 64 or 32, halved at double speed.
// [R7] Multiprocessor enable gates reception on the ninth bit, or stop bit in 8-bit mode.
// [R8] Software keeps multiprocessor enable at zero in shift mode.
// [R9] In 9-bit modes the received ninth bit is loaded from every frame.
// [R10] In 8-bit mode the received ninth bit field takes the stop bit.
// [R11] Transmit done rises after bit 8 in shift mode, else when the stop bit begins.
// [R12] Software clears the done flags; the hardware never clears them.
// [R13] Frames are taken only while receive enable is one.
// [R14] In 9-bit modes the transmit ninth bit field is sent as the ninth bit.
// [R15] Receive done rises after bit 8 in shift mode, else mid stop bit.
//
// Implementation choice: the Wishbone slave port.
`default_nettype none
module sps_serial_port
   import sps_pkg::*;
(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // serial pins
   input  wire logic        rxd_i,
   output logic             rxd_o,
   output logic             rxd_oe_o,
   output logic             txd_o,
   // interrupt
   output logic             irq_o
);
   // ==========================================
   // declarations
   sps_state_type s_r;
   sps_state_type s_nxt;
   sps_mode_type  mode;
   logic          rxd_sync;
   logic          tick;
   logic [15:0]   tick_div;
   logic          ninth;
   logic          shift;
   logic [3:0]    last_tick;
   logic [3:0]    last_bit;
   logic          req;
   logic          bus_wr;
   logic [7:0]    scs_rd;
   logic [8:0]    rx_shift_in;
   logic          tx_end;
   logic          rx_end;
   logic          rx_mid;
   logic          ninth_val;
   logic          tb8_sent_r;

   // ==========================================
   // decode of mode and bus strobes
   // [R4] mode bits decode
   assign mode      = sps_mode_type'({s_r.mode_select_hi, s_r.mode_select_lo});
   assign shift     = (mode == SPS_MODE_SHIFT);
   assign ninth     = s_r.mode_select_hi;
   assign last_tick = shift ? SPS_SHIFT_LAST_TICK : SPS_UART_LAST_TICK;
   assign last_bit  = ninth ? SPS_LAST_BIT_NINE : SPS_LAST_BIT_EIGHT;
   assign req       = wb_cyc_i & wb_stb_i;
   assign bus_wr    = req & wb_we_i & s_r.ack & wb_sel_i[0];
   assign tx_end    = tick & (s_r.tx_tk == last_tick);
   assign rx_end    = tick & (s_r.rx_tk == last_tick);
   assign rx_mid    = tick & (s_r.rx_tk == SPS_UART_MID_TICK);
   assign rx_shift_in = {rxd_sync, s_r.rx_sh[8:1]};
   assign ninth_val = ninth ? s_r.rx_sh[8] : rxd_sync;

   // ==========================================
   // bit-rate tick selection
   // [R5] [R6] fixed divisors
   always_comb
   begin
      case (mode)
         SPS_MODE_SHIFT:
            tick_div = s_r.double_speed_clocking ? SPS_TDIV_SHIFT_X2 : SPS_TDIV_SHIFT;
         SPS_MODE_FIXED:
         begin
            if (s_r.rate_fast)
               tick_div = s_r.double_speed_clocking ? SPS_TDIV_FAST_X2 : SPS_TDIV_FAST;
            else
               tick_div = s_r.double_speed_clocking ? SPS_TDIV_SLOW_X2 : SPS_TDIV_SLOW;
         end
         default:
            tick_div = s_r.var_div;
      endcase
   end

   sps_rate_gen u_rate
   (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .div_i  (tick_div),
      .tick_o (tick)
   );

   sps_sync2 #(.RESET_VAL(1'b1)) u_rxd_sync
   (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   (rxd_i),
      .q_o   (rxd_sync)
   );

   // ==========================================
   // serial control status read view
   // [R3] bit 7 multiplex
   always_comb
   begin
      scs_rd = 8'h00;
      scs_rd[SPS_SCS_ERR_MODE_HI] = s_r.error_view_select ? s_r.frame_error_flag
                                                          : s_r.mode_select_hi;
      scs_rd[SPS_SCS_MODE_LO]   = s_r.mode_select_lo;
      scs_rd[SPS_SCS_MULTIPROC] = s_r.multiproc_enable;
      scs_rd[SPS_SCS_RX_ENABLE] = s_r.rx_enable;
      scs_rd[SPS_SCS_TX_NINTH]  = s_r.tx_ninth_bit;
      scs_rd[SPS_SCS_RX_NINTH]  = s_r.rx_ninth_bit;
      scs_rd[SPS_SCS_TX_DONE]   = s_r.tx_done_flag;
      scs_rd[SPS_SCS_RX_DONE]   = s_r.rx_done_flag;
   end

   // ==========================================
   // next-state logic: bus first, engines after so hardware sets win
   always_comb
   begin
      s_nxt     = s_r;
      s_nxt.ack = req & ~s_r.ack;
      // read data captured as ack rises
      if (req & ~s_r.ack)
      begin
         case (wb_adr_i)
            SPS_OFS_SERIAL_CONTROL_STATUS: s_nxt.dat = {24'h000000, scs_rd};
            SPS_OFS_AUX_CTRL:   s_nxt.dat = {29'h00000000, s_r.rate_fast,
                                    s_r.double_speed_clocking, s_r.error_view_select};
            SPS_OFS_RATE_DIV:   s_nxt.dat = {16'h0000, s_r.var_div};
            SPS_OFS_RX_DATA:    s_nxt.dat = {24'h000000, s_r.rx_buf};
            SPS_OFS_IRQ_STATUS: s_nxt.dat = {29'h00000000, s_r.irq_st};
            SPS_OFS_IRQ_ENABLE: s_nxt.dat = {29'h00000000, s_r.irq_en};
            default:            s_nxt.dat = 32'h00000000;
         endcase
      end

      // register writes commit on the edge that sees ack
      if (bus_wr)
      begin
         case (wb_adr_i)
            SPS_OFS_SERIAL_CONTROL_STATUS:
            begin
               // [R2] [R3] bit 7 write target
               if (s_r.error_view_select)
                  s_nxt.frame_error_flag = wb_dat_i[SPS_SCS_ERR_MODE_HI];
               else
                  s_nxt.mode_select_hi = wb_dat_i[SPS_SCS_ERR_MODE_HI];
               s_nxt.mode_select_lo   = wb_dat_i[SPS_SCS_MODE_LO];
               s_nxt.multiproc_enable = wb_dat_i[SPS_SCS_MULTIPROC];
               s_nxt.rx_enable        = wb_dat_i[SPS_SCS_RX_ENABLE];
               s_nxt.tx_ninth_bit     = wb_dat_i[SPS_SCS_TX_NINTH];
               s_nxt.rx_ninth_bit     = wb_dat_i[SPS_SCS_RX_NINTH];
               s_nxt.tx_done_flag     = wb_dat_i[SPS_SCS_TX_DONE];
               s_nxt.rx_done_flag     = wb_dat_i[SPS_SCS_RX_DONE];
            end
            SPS_OFS_AUX_CTRL:
            begin
               s_nxt.error_view_select     = wb_dat_i[SPS_AUX_ERR_VIEW];
               s_nxt.double_speed_clocking = wb_dat_i[SPS_AUX_DOUBLE];
               s_nxt.rate_fast             = wb_dat_i[SPS_AUX_RATE_FAST];
            end
            SPS_OFS_RATE_DIV:
            begin
               s_nxt.var_div[7:0] = wb_dat_i[7:0];
               if (wb_sel_i[1])
                  s_nxt.var_div[15:8] = wb_dat_i[15:8];
            end
            SPS_OFS_TX_DATA:
            begin
               // loading data starts a frame; ignored while busy
               if (s_r.tx_st == SPS_IDLE)
               begin
                  s_nxt.tx_sh  = {s_r.tx_ninth_bit, wb_dat_i[7:0]};
                  s_nxt.tx_st  = shift ? SPS_DATA : SPS_START;
                  s_nxt.tx_tk  = 4'h0;
                  s_nxt.tx_bit = 4'h0;
               end
            end
            SPS_OFS_IRQ_CLEAR:  s_nxt.irq_st = s_r.irq_st & ~wb_dat_i[2:0];
            SPS_OFS_IRQ_ENABLE: s_nxt.irq_en = wb_dat_i[2:0];
            default: ;
         endcase
      end

      // transmit engine
      if (tick & (s_r.tx_st != SPS_IDLE))
         s_nxt.tx_tk = tx_end ? 4'h0 : s_r.tx_tk + 4'h1;
      if (tx_end)
      begin
         case (s_r.tx_st)
            SPS_START: s_nxt.tx_st = SPS_DATA;
            SPS_DATA:
            begin
               // [R14] ninth bit shifts out last
               s_nxt.tx_sh = {1'b0, s_r.tx_sh[8:1]};
               if (s_r.tx_bit == last_bit)
               begin
                  // [R11] transmit done timing
                  s_nxt.tx_done_flag       = 1'b1;
                  s_nxt.irq_st[SPS_IRQ_TX] = 1'b1;
                  s_nxt.tx_st = shift ? SPS_IDLE : SPS_STOP;
               end
               else
                  s_nxt.tx_bit = s_r.tx_bit + 4'h1;
            end
            SPS_STOP:  s_nxt.tx_st = SPS_IDLE;
            default: ;
         endcase
      end

      // receive engine
      if (tick & (s_r.rx_st != SPS_IDLE))
         s_nxt.rx_tk = rx_end ? 4'h0 : s_r.rx_tk + 4'h1;
      case (s_r.rx_st)
         SPS_IDLE:
         begin
            // [R13] start only when enabled
            if (s_r.rx_enable)
            begin
               if (shift)
               begin
                  if (~s_r.rx_done_flag & (s_r.tx_st == SPS_IDLE))
                  begin
                     s_nxt.rx_st  = SPS_DATA;
                     s_nxt.rx_tk  = 4'h0;
                     s_nxt.rx_bit = 4'h0;
                  end
               end
               else if (~s_r.rxd_was_low & ~rxd_sync)
               begin
                  s_nxt.rx_st = SPS_START;
                  s_nxt.rx_tk = 4'h0;
               end
            end
         end
         SPS_START:
         begin
            // glitch that is gone by mid start bit is dropped
            if (rx_mid & rxd_sync)
               s_nxt.rx_st = SPS_IDLE;
            else if (rx_end)
            begin
               s_nxt.rx_st  = SPS_DATA;
               s_nxt.rx_bit = 4'h0;
            end
         end
         SPS_DATA:
         begin
            if (shift ? rx_end : rx_mid)
               s_nxt.rx_sh = rx_shift_in;
            if (rx_end)
            begin
               if (s_r.rx_bit != last_bit)
                  s_nxt.rx_bit = s_r.rx_bit + 4'h1;
               else if (shift)
               begin
                  // [R15] shift mode done after bit 8
                  s_nxt.rx_buf             = rx_shift_in[8:1];
                  s_nxt.rx_done_flag       = 1'b1;
                  s_nxt.irq_st[SPS_IRQ_RX] = 1'b1;
                  s_nxt.rx_st              = SPS_IDLE;
               end
               else
                  s_nxt.rx_st = SPS_STOP;
            end
         end
         SPS_STOP:
         begin
            if (rx_mid)
            begin
               // [R1] bad stop bit
               if (~rxd_sync)
               begin
                  s_nxt.frame_error_flag   = 1'b1;
                  s_nxt.irq_st[SPS_IRQ_FE] = 1'b1;
               end
               // [R9] [R10] ninth bit or stop bit
               s_nxt.rx_ninth_bit = ninth_val;
               // [R7] [R15] multiprocessor gate, done mid stop
               if (~s_r.multiproc_enable | ninth_val)
               begin
                  s_nxt.rx_buf = ninth ? s_r.rx_sh[7:0] : s_r.rx_sh[8:1];
                  s_nxt.rx_done_flag       = 1'b1;
                  s_nxt.irq_st[SPS_IRQ_RX] = 1'b1;
               end
               s_nxt.rx_st = SPS_IDLE;
            end
         end
         default: s_nxt.rx_st = SPS_IDLE;
      endcase
      // [R13] disabling receive abandons a frame
      if (~s_r.rx_enable)
         s_nxt.rx_st = SPS_IDLE;
      s_nxt.rxd_was_low = ~rxd_sync;

      // pin levels follow the next state
      if (shift)
      begin
         s_nxt.rxd_drive = (s_nxt.tx_st == SPS_DATA);
         s_nxt.rxd_out   = s_nxt.tx_sh[0];
         s_nxt.txd_low   = ((s_nxt.tx_st == SPS_DATA) | (s_nxt.rx_st == SPS_DATA))
                           & (s_nxt.tx_st == SPS_DATA ? s_nxt.tx_tk == 4'h0
                                                       : s_nxt.rx_tk == 4'h0);
      end
      else
      begin
         s_nxt.rxd_drive = 1'b0;
         s_nxt.rxd_out   = 1'b0;
         s_nxt.txd_low   = (s_nxt.tx_st == SPS_START)
                           | ((s_nxt.tx_st == SPS_DATA) & ~s_nxt.tx_sh[0]);
      end
   end

   // ==========================================
   // state register
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         s_r <= SPS_STATE_RESET;
      else
         s_r <= s_nxt;
   end

   // outputs
   assign wb_dat_o = s_r.dat;
   assign wb_ack_o = s_r.ack;
   assign txd_o    = ~s_r.txd_low;
   assign rxd_o    = s_r.rxd_out;
   assign rxd_oe_o = s_r.rxd_drive;
   assign irq_o    = |(s_r.irq_st & s_r.irq_en);

   // ==========================================
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // ninth bit captured at frame start
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         tb8_sent_r <= 1'b0;
      else if (bus_wr & (wb_adr_i == SPS_OFS_TX_DATA) & (s_r.tx_st == SPS_IDLE))
         tb8_sent_r <= s_r.tx_ninth_bit;
   end

   // [R1] error on bad stop
   property p_fe_set;
      (s_r.rx_st == SPS_STOP) && rx_mid && !rxd_sync |=> s_r.frame_error_flag;
   endproperty
   a_fe_set: assert property (p_fe_set) else $error("frame error not set"); // [R1]

   // [R2] error flag sticky
   property p_fe_sticky;
      s_r.frame_error_flag && !(bus_wr && (wb_adr_i == SPS_OFS_SERIAL_CONTROL_STATUS)
         && s_r.error_view_select && !wb_dat_i[SPS_SCS_ERR_MODE_HI])
      |=> s_r.frame_error_flag;
   endproperty
   a_fe_sticky: assert property (p_fe_sticky) else $error("frame error lost"); // [R2]

   // [R3] bit 7 read view
   property p_bit7_view;
      req && !s_r.ack && (wb_adr_i == SPS_OFS_SERIAL_CONTROL_STATUS)
      |=> wb_ack_o && wb_dat_o[7] == ($past(s_r.error_view_select) ?
          $past(s_r.frame_error_flag) : $past(s_r.mode_select_hi));
   endproperty
   a_bit7_view: assert property (p_bit7_view) else $error("bit 7 view wrong"); // [R3]

   // [R5] shift rate spacing
   property p_shift_rate;
      tick && shift && !s_r.double_speed_clocking
      |=> (!tick || $past(!shift || s_r.double_speed_clocking)) [*5]
          ##1 (tick || $past(!shift || s_r.double_speed_clocking));
   endproperty
   a_shift_rate: assert property (p_shift_rate) else $error("shift rate wrong"); // [R5]

   // [R6] fixed rate spacing
   property p_fixed_rate;
      tick && (mode == SPS_MODE_FIXED) && !s_r.rate_fast && !s_r.double_speed_clocking
      |=> (!tick || $past(s_r.rate_fast || s_r.double_speed_clocking
                          || (mode != SPS_MODE_FIXED))) [*3]
          ##1 (tick || $past(s_r.rate_fast || s_r.double_speed_clocking
                             || (mode != SPS_MODE_FIXED)));
   endproperty
   a_fixed_rate: assert property (p_fixed_rate) else $error("fixed rate wrong"); // [R6]

   // [R9] ninth bit loaded
   property p_rx_ninth;
      (s_r.rx_st == SPS_STOP) && rx_mid && ninth |=> s_r.rx_ninth_bit == $past(s_r.rx_sh[8]);
   endproperty
   a_rx_ninth: assert property (p_rx_ninth) else $error("ninth bit not loaded"); // [R9]

   // [R10] stop bit kept
   property p_rx_stop8;
      (s_r.rx_st == SPS_STOP) && rx_mid && (mode == SPS_MODE_UART8)
      |=> s_r.rx_ninth_bit == $past(rxd_sync);
   endproperty
   a_rx_stop8: assert property (p_rx_stop8) else $error("stop bit not loaded"); // [R10]

   // [R11] done at stop start
   property p_tx_done;
      (s_r.tx_st == SPS_DATA) ##1 (s_r.tx_st == SPS_STOP) |-> s_r.tx_done_flag;
   endproperty
   a_tx_done: assert property (p_tx_done) else $error("transmit done late"); // [R11]

   // [R13] receiver held idle
   property p_rx_off;
      !s_r.rx_enable |=> s_r.rx_st == SPS_IDLE ##1 s_r.rx_st == SPS_IDLE || s_r.rx_enable;
   endproperty
   a_rx_off: assert property (p_rx_off) else $error("receive while disabled"); // [R13]

   // [R14] ninth bit on the line
   property p_tx_ninth;
      (s_r.tx_st == SPS_DATA) && (s_r.tx_bit == SPS_LAST_BIT_NINE) |-> txd_o == tb8_sent_r;
   endproperty
   a_tx_ninth: assert property (p_tx_ninth) else $error("ninth bit wrong"); // [R14]
endmodule
`default_nettype wire

// >>> tb/sps_node_model.sv
`default_nettype none
// ==========================================
// remote serial node: sends frames on the line
module sps_node_model
(
   output logic line_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // idle line is high
   initial line_o = 1'b1;
   // frame sender, 16 clocks a bit, lsb first
   task automatic send(input logic [10:0] f);
      for (int i = 0; i < 11; i++)
      begin
         line_o <= f[i];
         #320;
      end
      line_o <= 1'b1;
   endtask
endmodule
`default_nettype wire

// >>> tb/serial_port_control_status_tb.sv
`default_nettype none
// ==========================================
// testbench
module serial_port_control_status_tb;
   import sps_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
   logic [7:0]  adr = '0;
   logic [31:0] dat = '0, rdat, q;
   logic        ack, rxd, txd, irq, sd, soe;
   int          n_mismatch = 0, checks = 0, t;
   sps_node_model u_node (.line_o(rxd));
   sps_serial_port u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_sel_i(4'hF), .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .rxd_i(rxd), .rxd_o(sd), .rxd_oe_o(soe), .txd_o(txd), .irq_o(irq));
   // clock
   initial forever #10 clk_i = ~clk_i;
   // one wishbone classic cycle
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      dat <= d;
      do
      begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      // a missing acknowledge counts as a mismatch
      if (ack !== 1'b1)
         n_mismatch++;
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   // compare one value
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   // verdict
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // watchdog
   initial
   begin
      #300000;
      n_mismatch++;
      wrap_up();
   end
   // tests
   initial
   begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(0, 8'h98, '0);
      chk("serial_control_status_reset", 32'h0, q);
      wb(0, 8'hFC, '0);
      chk("unmapped", 32'h0, q);
      $display("test reset done");
      wb(1, 8'hA4, 32'h1);
      wb(1, 8'hB8, 32'h7);
      wb(1, 8'h98, 32'h50); // mode 1
      wb(1, 8'hA8, 32'hA5);
      t = 0;
      while (txd !== 1'b0 && t < 100)
      begin
         @(posedge clk_i);
         t++;
      end
      if (t == 100)
         n_mismatch++;
      repeat (8) @(posedge clk_i);
      for (int i = 0; i < 8; i++)
      begin
         repeat (16) @(posedge clk_i);
         chk("txd_bit", 32'((8'hA5 >> i) & 8'h1), {31'h0, txd});
      end
      repeat (16) @(posedge clk_i);
      chk("txd_stop", 32'h1, {31'h0, txd});
      wb(0, 8'h98, '0);
      chk("serial_control_status_tx_done", 32'h52, q);
      chk("irq_tx", 32'h1, {31'h0, irq});
      wb(1, 8'h98, 32'h50); // software acknowledge
      wb(1, 8'hB4, 32'h7);
      wb(0, 8'h98, '0);
      chk("serial_control_status_ack", 32'h50, q);
      chk("irq_clear", 32'h0, {31'h0, irq});
      $display("test transmit done");
      wb(1, 8'h98, 32'hD0);
      wb(1, 8'hA0, 32'h1);
      u_node.send({1'b0, 1'b1, 8'h3C, 1'b0});
      wb(0, 8'h98, '0);
      chk("serial_control_status_bad_stop", 32'hD5, q);
      wb(0, 8'hAC, '0);
      chk("rx_data", 32'h3C, q);
      u_node.send({1'b1, 1'b0, 8'h5A, 1'b0});
      wb(0, 8'h98, '0);
      chk("serial_control_status_fe_sticky", 32'hD1, q);
      wb(1, 8'h98, 32'h50);
      wb(0, 8'h98, '0);
      chk("serial_control_status_fe_view", 32'h50, q);
      wb(1, 8'hA0, 32'h0);
      wb(0, 8'h98, '0);
      chk("serial_control_status_mode_view", 32'hD0, q);
      $display("test receive done");
      wb(1, 8'h98, 32'hC0);
      u_node.send({1'b1, 1'b1, 8'h11, 1'b0});
      wb(0, 8'h98, '0);
      chk("serial_control_status_rx_off", 32'hC0, q);
      wb(1, 8'h98, 32'hF0);
      u_node.send({1'b1, 1'b0, 8'h22, 1'b0});
      wb(0, 8'h98, '0);
      chk("serial_control_status_mp_skip", 32'hF0, q);
      u_node.send({1'b1, 1'b1, 8'h33, 1'b0});
      wb(0, 8'h98, '0);
      chk("serial_control_status_mp_take", 32'hF5, q);
      wb(0, 8'hAC, '0);
      chk("rx_data_mp", 32'h33, q);
      $display("test multiprocessor done");
      // 8-bit receive keeps the stop bit
      wb(1, 8'h98, 32'h50);
      u_node.send({1'b1, 1'b1, 8'h6C, 1'b0});
      wb(0, 8'h98, '0);
      chk("serial_control_status_stop8", 32'h55, q);
      $display("test eight bit receive done");
      // shift mode transmit, 12 clocks a bit
      wb(1, 8'h98, 32'h00); // multiprocessor off in shift mode
      wb(1, 8'hA8, 32'h02);
      repeat (18) @(posedge clk_i);
      chk("shift_bit1", 32'h1, {31'h0, sd});
      chk("shift_oe", 32'h1, {31'h0, soe});
      repeat (80) @(posedge clk_i);
      wb(0, 8'h98, '0);
      chk("serial_control_status_shift_done", 32'h02, q);
      $display("test shift done");
      // fixed 9-bit mode, 64 clocks a bit, ninth bit set
      wb(1, 8'h98, 32'h88);
      wb(1, 8'hA8, 32'h00);
      repeat (544) @(posedge clk_i);
      chk("fixed_bit7", 32'h0, {31'h0, txd});
      repeat (64) @(posedge clk_i);
      chk("fixed_ninth", 32'h1, {31'h0, txd});
      $display("test fixed rate done");
      wrap_up();
   end
endmodule
`default_nettype wire
